// [rtl/vsp_pkg.sv]
// video sync processor: register map, field positions, reset values, timing
// assumes a 50 MHz APB clock; all times are turned into cycles or ticks here
package vsp_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DIV_HIGH = 8'h01;
  localparam logic [7:0] IDX_DIV_LOW = 8'h02;
  localparam logic [7:0] IDX_VCO_RANGE = 8'h03;
  localparam logic [7:0] IDX_SRC_OVERRIDE = 8'h0e;
  localparam logic [7:0] IDX_COAST_CTRL = 8'h0f;
  localparam logic [7:0] IDX_DETECT_STATUS = 8'h14;
  localparam logic [7:0] IDX_SEP_LENGTH = 8'h18;
  localparam logic [7:0] IDX_PATH_CTRL = 8'h19;

  // reset values; divider 1693 = 12'h69d split as high byte and low nibble
  localparam logic [7:0] RST_DIV_HIGH = 8'h69;
  localparam logic [7:0] RST_DIV_LOW = 8'hd0;
  localparam logic [7:0] RST_VCO_RANGE = 8'h00;
  localparam logic [7:0] RST_SRC_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_COAST_CTRL = 8'h00;
  localparam logic [7:0] RST_SEP_LENGTH = 8'h20;
  localparam logic [7:0] RST_PATH_CTRL = 8'h00;

  // field positions
  localparam int VCO_MSB_POS = 7;
  localparam int VCO_LSB_POS = 6;
  localparam int OVR_HREF_EN_POS = 4;
  localparam int OVR_HREF_VAL_POS = 3;
  localparam int OVR_VSRC_EN_POS = 1;
  localparam int OVR_VSRC_VAL_POS = 0;
  localparam int COAST_EXT_POS = 5;
  localparam int PATH_MUX_POS = 0;
  localparam int ST_HS_ACT_POS = 7;
  localparam int ST_HS_POL_POS = 5;
  localparam int ST_VS_ACT_POS = 4;
  localparam int ST_VOUT_POL_POS = 2;
  localparam int ST_GS_ACT_POS = 1;
  localparam int ST_COAST_POL_POS = 0;

  // divider limits
  localparam logic [12:0] DIV_RATIO_MIN = 13'h0011;

  // timebase: about 5 MHz derived from the 50 MHz bus clock
  localparam int CLK_MHZ = 50;
  localparam int TIMEBASE_MHZ = 5;
  localparam logic [3:0] TB_DIV_CYCLES = 4'(CLK_MHZ / TIMEBASE_MHZ);

  // activity window: no edge within this time means inactive
  localparam int ACT_WINDOW_US = 40000;
  localparam int ACT_WINDOW_TICKS = ACT_WINDOW_US * TIMEBASE_MHZ;
  localparam int IDLE_W = 18;
  localparam int DUTY_W = 20;
endpackage : vsp_pkg

// [rtl/vsp_sync_proc.sv]
// video sync processor: activity and polarity detection, source selection,
// sync separator and pll divider/vco settings behind an apb slave
// assumes sync pins are asynchronous to pclk and pass a two-stage synchroniser
//
// Behaviour
// - slicer output keeps green sync polarity; normal video gives active-low pulses.
// - detect slicer output activity; report in status bit 1.
// - detect horizontal sync toggling; report in status bit 7.
// - pll reference: hsync default, slicer if only it active, else override bit 3.
// - horizontal sync mostly low is positive, mostly high negative; status bit 5.
// - selected horizontal sync is polarity corrected before the pll reference.
// - mux routes slicer or horizontal sync into the separator as composite sync.
// - separator length programmable 0 to 255 ticks, default 32.
// - separator rejects changes shorter than the length, passing vertical sync.
// - separator ticks come from a 5 MHz timebase, not the pixel clock.
// - vertical sync input or separator output can drive the coast control.
// - detect vertical sync input toggling; report in status bit 4.
// - vertical output polarity from duty cycle; status bit 2.
// - vertical source: input if active, separator if only slicer, else bit 0.
// - feedback divider is 12 bits, usable ratio 17 to 4096.
// - division ratio is programmed value plus one, pixels per line.
// - divider resets to 1693, ratio 1694.
// - top two bits of vco range register select the vco band.
// - pixel clock locks to the selected horizontal sync reference.
// - coast control bit 5 picks internal sync coast or external coast input.
// - coast polarity from duty cycle, mostly low positive; status bit 0.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps

module vsp_sync_proc
  import vsp_pkg::*;
#(
  parameter logic [IDLE_W-1:0] ACT_WINDOW = IDLE_W'(ACT_WINDOW_TICKS)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic green_sync_slicer_out,
  input wire logic coast_in,
  output logic pll_reference,
  output logic pll_reference_select,
  output logic vertical_sync_output,
  output logic vertical_source_select,
  output logic pll_coast,
  output logic [12:0] pll_divide_ratio,
  output logic vco_range_msb,
  output logic vco_range_lsb
);

  // input slots: 0 hsync, 1 vsync, 2 green slicer, 3 coast
  typedef struct packed {
    logic [3:0] tb_cnt;
    logic tick;
    logic [1:0] warm;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [2:0][IDLE_W-1:0] idle;
    logic [2:0] active;
    logic [2:0][DUTY_W-1:0] duty;
    logic sep_out;
    logic [7:0] sep_cnt;
    logic href;
    logic vout;
    logic coast;
    logic [7:0] div_high;
    logic [7:0] div_low;
    logic [7:0] vco;
    logic [7:0] ovr;
    logic [7:0] coast_ctrl;
    logic [7:0] sep_len;
    logic [7:0] path;
    logic [31:0] rdata;
  } vsp_state_t;

  vsp_state_t st_r;
  vsp_state_t st_nxt;

  logic [3:0] pins;
  logic [7:0] idx;
  logic mapped;
  logic wr_en;
  logic [7:0] status;
  logic [2:0] pol;
  logic href_sel;
  logic vsrc_sel;
  logic [2:0] duty_lvl;
  logic composite;
  logic [11:0] div_val;
  logic [12:0] ratio_raw;

  assign pins = {coast_in, green_sync_slicer_out, vsync_in, hsync_in};
  assign idx = paddr[9:2];
  assign mapped = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h000000) &&
                  (idx == IDX_DIV_HIGH || idx == IDX_DIV_LOW || idx == IDX_VCO_RANGE ||
                   idx == IDX_SRC_OVERRIDE || idx == IDX_COAST_CTRL ||
                   idx == IDX_DETECT_STATUS || idx == IDX_SEP_LENGTH ||
                   idx == IDX_PATH_CTRL);
  assign wr_en = psel && penable && pwrite && mapped && pstrb[0];

  // duty counter below half scale means mostly low, reported positive
  assign pol[0] = ~st_r.duty[0][DUTY_W-1];
  assign pol[1] = ~st_r.duty[1][DUTY_W-1];
  assign pol[2] = ~st_r.duty[2][DUTY_W-1];

  always_comb begin
    status = 8'h00;
    status[ST_HS_ACT_POS] = st_r.active[0];
    status[ST_HS_POL_POS] = pol[0];
    status[ST_VS_ACT_POS] = st_r.active[1];
    status[ST_VOUT_POL_POS] = pol[1];
    status[ST_GS_ACT_POS] = st_r.active[2];
    status[ST_COAST_POL_POS] = pol[2];
  end

  always_comb begin
    if (st_r.ovr[OVR_HREF_EN_POS] || (st_r.active[0] && st_r.active[2])) begin
      href_sel = st_r.ovr[OVR_HREF_VAL_POS];
    end else begin
      href_sel = ~st_r.active[0] && st_r.active[2];
    end
    if (st_r.ovr[OVR_VSRC_EN_POS] || (!st_r.active[1] && !st_r.active[2])) begin
      vsrc_sel = st_r.ovr[OVR_VSRC_VAL_POS];
    end else begin
      vsrc_sel = ~st_r.active[1];
    end
  end

  // composite sync for the separator, slicer passed with its own polarity
  assign composite = st_r.path[PATH_MUX_POS] ? st_r.sync2[0] : st_r.sync2[2];
  assign duty_lvl = {st_r.coast, st_r.vout, st_r.sync2[0]};

  assign div_val = {st_r.div_high, st_r.div_low[7:4]};
  assign ratio_raw = {1'b0, div_val} + 13'h0001;
  assign pll_divide_ratio = (ratio_raw < DIV_RATIO_MIN) ? DIV_RATIO_MIN : ratio_raw;

  always_comb begin
    st_nxt = st_r;
    // timebase divider, one-cycle tick every ten clocks
    st_nxt.tick = 1'b0;
    if (st_r.tb_cnt == TB_DIV_CYCLES - 4'h1) begin
      st_nxt.tb_cnt = 4'h0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tb_cnt = st_r.tb_cnt + 4'h1;
    end

    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;

    // reset leaves prev at zero, so edges count only once prev holds a real
    // pin sample; otherwise a pin idling high would read active after reset
    if (st_r.warm != 2'h3) begin
      st_nxt.warm = st_r.warm + 2'h1;
    end

    // activity: any edge restarts the idle window
    for (int i = 0; i < 3; i++) begin
      if (st_r.warm == 2'h3 && st_r.sync2[i] != st_r.prev[i]) begin
        st_nxt.idle[i] = '0;
        st_nxt.active[i] = 1'b1;
      end else if (st_r.tick) begin
        if (st_r.idle[i] >= ACT_WINDOW) begin
          st_nxt.active[i] = 1'b0;
        end else begin
          st_nxt.idle[i] = st_r.idle[i] + 1'b1;
        end
      end
    end

    // saturating up/down duty counters; wide so a short pulse barely moves them
    if (st_r.tick) begin
      for (int i = 0; i < 3; i++) begin
        if (duty_lvl[i] && st_r.duty[i] != '1) begin
          st_nxt.duty[i] = st_r.duty[i] + 1'b1;
        end else if (!duty_lvl[i] && st_r.duty[i] != '0) begin
          st_nxt.duty[i] = st_r.duty[i] - 1'b1;
        end
      end
    end

    // separator: a level change must persist sep_len plus one ticks to pass
    if (composite == st_r.sep_out) begin
      st_nxt.sep_cnt = 8'h00;
    end else if (st_r.tick) begin
      if (st_r.sep_cnt >= st_r.sep_len) begin
        st_nxt.sep_out = composite;
        st_nxt.sep_cnt = 8'h00;
      end else begin
        st_nxt.sep_cnt = st_r.sep_cnt + 8'h01;
      end
    end

    // reference is made active-high: slicer is active-low, hsync by its polarity
    if (href_sel) begin
      st_nxt.href = ~st_r.sync2[2];
    end else begin
      st_nxt.href = st_r.sync2[0] ^ ~pol[0];
    end
    st_nxt.vout = vsrc_sel ? st_r.sep_out : st_r.sync2[1];
    st_nxt.coast = st_r.coast_ctrl[COAST_EXT_POS] ? st_r.sync2[3] : st_r.vout;

    // apb: read data captured in the setup cycle, shown in the access cycle
    if (psel && !penable) begin
      case (idx)
        IDX_DIV_HIGH: st_nxt.rdata = {24'h000000, st_r.div_high};
        IDX_DIV_LOW: st_nxt.rdata = {24'h000000, st_r.div_low[7:4], 4'h0};
        IDX_VCO_RANGE: st_nxt.rdata = {24'h000000, st_r.vco};
        IDX_SRC_OVERRIDE: st_nxt.rdata = {24'h000000, st_r.ovr};
        IDX_COAST_CTRL: st_nxt.rdata = {24'h000000, st_r.coast_ctrl};
        IDX_DETECT_STATUS: st_nxt.rdata = {24'h000000, status};
        IDX_SEP_LENGTH: st_nxt.rdata = {24'h000000, st_r.sep_len};
        IDX_PATH_CTRL: st_nxt.rdata = {24'h000000, st_r.path};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
    // status has no write path, writes to it are accepted and dropped
    if (wr_en) begin
      case (idx)
        IDX_DIV_HIGH: st_nxt.div_high = pwdata[7:0];
        IDX_DIV_LOW: st_nxt.div_low = {pwdata[7:4], 4'h0};
        IDX_VCO_RANGE: st_nxt.vco = pwdata[7:0];
        IDX_SRC_OVERRIDE: st_nxt.ovr = pwdata[7:0];
        IDX_COAST_CTRL: st_nxt.coast_ctrl = pwdata[7:0];
        IDX_SEP_LENGTH: st_nxt.sep_len = pwdata[7:0];
        IDX_PATH_CTRL: st_nxt.path = pwdata[7:0];
        default: st_nxt.rdata = st_nxt.rdata;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.tb_cnt <= 4'h0;
      st_r.tick <= 1'b0;
      st_r.warm <= 2'h0;
      st_r.sync1 <= 4'h0;
      st_r.sync2 <= 4'h0;
      st_r.prev <= 4'h0;
      st_r.idle <= '0;
      st_r.active <= 3'h0;
      st_r.duty <= '1;
      st_r.sep_out <= 1'b0;
      st_r.sep_cnt <= 8'h00;
      st_r.href <= 1'b0;
      st_r.vout <= 1'b0;
      st_r.coast <= 1'b0;
      st_r.div_high <= RST_DIV_HIGH;
      st_r.div_low <= RST_DIV_LOW;
      st_r.vco <= RST_VCO_RANGE;
      st_r.ovr <= RST_SRC_OVERRIDE;
      st_r.coast_ctrl <= RST_COAST_CTRL;
      st_r.sep_len <= RST_SEP_LENGTH;
      st_r.path <= RST_PATH_CTRL;
      st_r.rdata <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign pll_reference = st_r.href;
  assign pll_reference_select = href_sel;
  assign vertical_sync_output = st_r.vout;
  assign vertical_source_select = vsrc_sel;
  assign pll_coast = st_r.coast;
  assign vco_range_msb = st_r.vco[VCO_MSB_POS];
  assign vco_range_lsb = st_r.vco[VCO_LSB_POS];

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_tick_period;
    st_r.tick |=> !st_r.tick [*8] ##1 !st_r.tick ##1 st_r.tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("timebase tick not every ten clocks");

  property p_href_sel;
    (!st_r.ovr[OVR_HREF_EN_POS] && !st_r.active[0] && st_r.active[2]) |-> href_sel;
  endproperty
  a_href_sel: assert property (p_href_sel)
    else $error("slicer alone active but hsync chosen");

  property p_href_ovr;
    st_r.ovr[OVR_HREF_EN_POS] |-> (href_sel == st_r.ovr[OVR_HREF_VAL_POS]);
  endproperty
  a_href_ovr: assert property (p_href_ovr)
    else $error("reference override ignored");

  property p_vsrc_sel;
    (!st_r.ovr[OVR_VSRC_EN_POS] && st_r.active[1]) |-> !vsrc_sel;
  endproperty
  a_vsrc_sel: assert property (p_vsrc_sel)
    else $error("active vsync input not chosen");

  property p_hs_active;
    (st_r.warm == 2'h3 && st_r.sync2[0] != st_r.prev[0]) |=> status[ST_HS_ACT_POS];
  endproperty
  a_hs_active: assert property (p_hs_active)
    else $error("hsync edge did not set activity");

  property p_gs_idle;
    (st_r.tick && st_r.idle[2] >= ACT_WINDOW && st_r.sync2[2] == st_r.prev[2])
      |=> !status[ST_GS_ACT_POS];
  endproperty
  a_gs_idle: assert property (p_gs_idle)
    else $error("slicer activity not dropped after idle window");

  property p_sep_on_tick;
    $changed(st_r.sep_out) |-> $past(st_r.tick) && $past(composite) == st_r.sep_out;
  endproperty
  a_sep_on_tick: assert property (p_sep_on_tick)
    else $error("separator output changed off a tick");

  property p_ratio;
    (div_val >= 12'h010) |-> (pll_divide_ratio == {1'b0, div_val} + 13'h0001);
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("division ratio is not setting plus one");

  property p_vco;
    $past(wr_en) && $past(idx) == IDX_VCO_RANGE
      |-> {vco_range_msb, vco_range_lsb} == $past(pwdata[7:6]);
  endproperty
  a_vco: assert property (p_vco)
    else $error("vco range bits not taken from write");

  property p_href_pol;
    $past(presetn) && !$past(href_sel)
      |-> pll_reference == ($past(st_r.sync2[0]) ^ ~$past(pol[0]));
  endproperty
  a_href_pol: assert property (p_href_pol)
    else $error("hsync reference polarity not corrected");

  property p_gs_active;
    (st_r.warm == 2'h3 && st_r.sync2[2] != st_r.prev[2]) |=> status[ST_GS_ACT_POS];
  endproperty
  a_gs_active: assert property (p_gs_active)
    else $error("slicer edge did not set activity");

  property p_vs_active;
    (st_r.warm == 2'h3 && st_r.sync2[1] != st_r.prev[1]) |=> status[ST_VS_ACT_POS];
  endproperty
  a_vs_active: assert property (p_vs_active)
    else $error("vsync edge did not set activity");

  property p_ref_slicer;
    $past(presetn) && $past(href_sel) |-> pll_reference == !$past(st_r.sync2[2]);
  endproperty
  a_ref_slicer: assert property (p_ref_slicer)
    else $error("slicer reference not taken as active-low");

  property p_vout_vsync;
    $past(presetn) && !$past(vsrc_sel) |-> vertical_sync_output == $past(st_r.sync2[1]);
  endproperty
  a_vout_vsync: assert property (p_vout_vsync)
    else $error("vertical output does not follow the vsync input");

  property p_coast_ext;
    st_r.coast_ctrl[COAST_EXT_POS] |=> pll_coast == $past(st_r.sync2[3]);
  endproperty
  a_coast_ext: assert property (p_coast_ext)
    else $error("external coast input not passed to coast control");

endmodule // vsp_sync_proc

// [testbench/vsp_sync_proc_tb.sv]
// self-checking bench for the sync processor, apb master plus source model
// assumes a shortened activity window; polarity stays at its reset reading
`timescale 1ns/10ps

module vsp_sync_proc_tb;
  import vsp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic hs_run = 1'b0, gs_run = 1'b0, vs_run = 1'b0;
  logic hs_lvl = 1'b1, gs_lvl = 1'b1, vs_lvl = 1'b1, coast_lvl = 1'b0;
  logic hsync_in, vsync_in, gs_out, coast_in;
  logic pll_ref, ref_sel, vso, vsrc_sel, coast, vmsb, vlsb;
  logic [12:0] ratio;
  int err_count = 0;
  int compares = 0;

  always #10 pclk = ~pclk;

  vsp_sync_proc #(.ACT_WINDOW(18'h00032)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .green_sync_slicer_out(gs_out),
    .coast_in(coast_in), .pll_reference(pll_ref), .pll_reference_select(ref_sel),
    .vertical_sync_output(vso), .vertical_source_select(vsrc_sel),
    .pll_coast(coast), .pll_divide_ratio(ratio),
    .vco_range_msb(vmsb), .vco_range_lsb(vlsb));

  vsp_video_source u_src (
    .pclk(pclk), .hs_run(hs_run), .gs_run(gs_run), .vs_run(vs_run),
    .hs_lvl(hs_lvl), .gs_lvl(gs_lvl), .vs_lvl(vs_lvl), .coast_lvl(coast_lvl),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .green_sync_slicer_out(gs_out),
    .coast_in(coast_in));

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // hold the request until pready is seen at an edge, then release
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_count++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(er, e);
  endtask

  // ports are looked at mid-cycle, well away from the launching edge
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic t_reset;
    rchk(32'h04, 32'h69, 1'b0);
    rchk(32'h08, 32'hd0, 1'b0);
    rchk(32'h0c, 32'h00, 1'b0);
    rchk(32'h38, 32'h00, 1'b0);
    rchk(32'h50, 32'h00, 1'b0);
    rchk(32'h60, 32'h20, 1'b0);
    rchk(32'h10, 32'h00, 1'b1);
    chk(ratio, 32'h069e);
    wr(32'h50, 32'hff);
    rchk(32'h50, 32'h00, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_div;
    wr(32'h04, 32'h41);
    wr(32'h08, 32'hff);
    rchk(32'h08, 32'hf0, 1'b0);
    chk(ratio, 32'h0420);
    wr(32'h04, 32'h00);
    wr(32'h08, 32'h00);
    wt(1);
    chk(ratio, 32'h0011);
    wr(32'h04, 32'hff);
    wr(32'h08, 32'hf0);
    wt(1);
    chk(ratio, 32'h1000);
    for (int i = 0; i < 4; i++) begin
      wr(32'h0c, {24'h0, 2'(i), 6'h15});
      wt(2);
      chk(vmsb, 32'(i / 2));
      chk(vlsb, 32'(i % 2));
    end
    $display("test divider done");
  endtask

  task automatic t_act;
    hs_run <= 1'b1;
    wt(100);
    rchk(32'h50, 32'h80, 1'b0);
    chk(ref_sel, 32'h0);
    gs_run <= 1'b1;
    wt(100);
    rchk(32'h50, 32'h82, 1'b0);
    wr(32'h38, 32'h08);
    wt(1);
    chk(ref_sel, 32'h1);
    vs_run <= 1'b1;
    wt(100);
    rchk(32'h50, 32'h92, 1'b0);
    chk(vsrc_sel, 32'h0);
    wr(32'h38, 32'h03);
    wt(1);
    chk(vsrc_sel, 32'h1);
    chk(ref_sel, 32'h0);
    wr(32'h38, 32'h00);
    hs_run <= 1'b0;
    vs_run <= 1'b0;
    wt(800);
    rchk(32'h50, 32'h02, 1'b0);
    chk(ref_sel, 32'h1);
    chk(vsrc_sel, 32'h1);
    gs_run <= 1'b0;
    wt(800);
    rchk(32'h50, 32'h00, 1'b0);
    chk(vsrc_sel, 32'h0);
    wr(32'h38, 32'h01);
    wt(1);
    chk(vsrc_sel, 32'h1);
    $display("test activity done");
  endtask

  task automatic t_ref;
    hs_lvl <= 1'b0;
    wt(6);
    chk(pll_ref, 32'h1);
    hs_lvl <= 1'b1;
    wt(6);
    chk(pll_ref, 32'h0);
    wt(800);
    gs_lvl <= 1'b0;
    wt(6);
    chk(ref_sel, 32'h1);
    chk(pll_ref, 32'h1);
    gs_lvl <= 1'b1;
    wt(6);
    chk(pll_ref, 32'h0);
    $display("test reference done");
  endtask

  // length 3 needs a change to persist 4 ticks of 10 cycles
  task automatic t_sep;
    wr(32'h60, 32'h03);
    wr(32'h64, 32'h00);
    wr(32'h38, 32'h03);
    wt(100);
    chk(vso, 32'h1);
    gs_lvl <= 1'b0;
    wt(20);
    gs_lvl <= 1'b1;
    wt(5);
    chk(vso, 32'h1);
    wt(60);
    chk(vso, 32'h1);
    gs_lvl <= 1'b0;
    wt(100);
    chk(vso, 32'h0);
    chk(coast, 32'h0);
    gs_lvl <= 1'b1;
    wt(100);
    chk(coast, 32'h1);
    wr(32'h64, 32'h01);
    hs_lvl <= 1'b0;
    wt(100);
    chk(vso, 32'h0);
    hs_lvl <= 1'b1;
    wr(32'h60, 32'h00);
    wt(100);
    hs_lvl <= 1'b0;
    wt(25);
    chk(vso, 32'h0);
    hs_lvl <= 1'b1;
    $display("test separator done");
  endtask

  task automatic t_coast;
    wr(32'h3c, 32'h20);
    rchk(32'h3c, 32'h20, 1'b0);
    coast_lvl <= 1'b1;
    wt(6);
    chk(coast, 32'h1);
    coast_lvl <= 1'b0;
    wt(6);
    chk(coast, 32'h0);
    $display("test coast done");
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_div();
    t_act();
    t_ref();
    t_sep();
    t_coast();
    report_and_stop();
  end

  initial begin
    #1000000;
    err_count++;
    report_and_stop();
  end
endmodule // vsp_sync_proc_tb

// [testbench/vsp_video_source.sv]
// video source model: drives hsync, vsync, slicer output and coast pins
// assumes pclk from the bench; pins change only just after a rising edge
`timescale 1ns/10ps

module vsp_video_source (
  input wire logic pclk,
  input wire logic hs_run,
  input wire logic gs_run,
  input wire logic vs_run,
  input wire logic hs_lvl,
  input wire logic gs_lvl,
  input wire logic vs_lvl,
  input wire logic coast_lvl,
  output logic hsync_in,
  output logic vsync_in,
  output logic green_sync_slicer_out,
  output logic coast_in
);
  logic [5:0] cnt_r = 6'h00;

  // free running: short low pulses on a mostly high line; else held level
  // a source without green sync still times the hsync or vsync pins
  // pins registered so they only move just after a rising edge
  always @(posedge pclk) begin
    cnt_r <= (cnt_r == 6'h27) ? 6'h00 : cnt_r + 6'h01;
    hsync_in <= hs_run ? (cnt_r > 6'h03) : hs_lvl;
    vsync_in <= vs_run ? (cnt_r > 6'h03) : vs_lvl;
    green_sync_slicer_out <= gs_run ? (cnt_r > 6'h03) : gs_lvl;
    coast_in <= coast_lvl;
  end
endmodule // vsp_video_source
